// ==== drive_admin_pkg.sv ====
// Constants for the drive administrative command handler.
// Assumes a 20 MHz ref_clk and an Avalon-MM master on the register bus.
// What this block does
// R1 - Query in standby: sector count 00h, interrupt
// R2 - Query while idle: sector count FFh, interrupt
// R3 - Opcode 92h streams new firmware words
// R4 - Overlay feature selects restore/freeze/identify/set
// R5 - Reserved overlay feature values abort
// R6 - Restore returns native capabilities and capacity
// R7 - After freeze, all overlay subcommands abort
// R8 - Freeze survives reset, cleared by power loss
// R9 - Identify returns 512 bytes by PIO in
// R10 - Identify reflects reduced capabilities after set
// R11 - Set overlay modifies selected capability words
// R12 - Cleared capability bit disables that feature
// R13 - Overlay bits absent natively are ignored
// R14 - Lowered max address changes native max report
// R15 - Word 1: multiword DMA bits 2-0
// R16 - Word 2: Ultra DMA bits 6-0
// R17 - Word 7: command set permission bits
// R18 - Word 8: serial link feature permissions
// R19 - Revision, max address, vendor area layout
// R20 - Word 255 signature plus zero-sum checksum
// R21 - Opcode 90h runs diagnostics into error
// R22 - Diagnostic codes 01h through 05h
// R23 - Multi-word values least significant word first
// R24 - Reserved bits and words read zero
package drive_admin_pkg;
  localparam logic [7:0] OPC_POWER_QUERY = 8'he5;
  localparam logic [7:0] OPC_UCODE = 8'h92;
  localparam logic [7:0] OPC_OVERLAY = 8'hb1;
  localparam logic [7:0] OPC_DIAG = 8'h90;
  localparam logic [7:0] FEAT_RESTORE = 8'hc0;
  localparam logic [7:0] FEAT_FREEZE = 8'hc1;
  localparam logic [7:0] FEAT_IDENTIFY = 8'hc2;
  localparam logic [7:0] FEAT_SET = 8'hc3;
  localparam logic [7:0] SC_STANDBY = 8'h00;
  localparam logic [7:0] SC_IDLE = 8'hff;
  localparam logic [7:0] ERR_ABORT = 8'h04;
  localparam logic [7:0] DIAG_PASS = 8'h01;
  localparam logic [7:0] DIAG_FORMATTER = 8'h02;
  localparam logic [7:0] DIAG_BUFFER = 8'h03;
  localparam logic [7:0] DIAG_ECC = 8'h04;
  localparam logic [7:0] DIAG_CPU = 8'h05;
  // Register byte addresses
  localparam logic [4:0] ADDR_CMD = 5'h00;
  localparam logic [4:0] ADDR_STATUS = 5'h04;
  localparam logic [4:0] ADDR_SECCNT = 5'h08;
  localparam logic [4:0] ADDR_ERROR = 5'h0c;
  localparam logic [4:0] ADDR_DATA = 5'h10;
  localparam logic [4:0] ADDR_POWER = 5'h14;
  // Status bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_DRQ = 1;
  localparam int ST_ERR = 2;
  localparam int ST_INTRQ = 3;
  // Power mode encodings
  localparam logic [1:0] PM_IDLE = 2'h0;
  localparam logic [1:0] PM_STANDBY = 2'h1;
  localparam logic [1:0] PM_ENTERING = 2'h2;
  localparam logic [1:0] PM_LEAVING = 2'h3;
  // Capability structure layout
  localparam logic [7:0] W_REV = 8'h00;
  localparam logic [7:0] W_MDMA = 8'h01;
  localparam logic [7:0] W_UDMA = 8'h02;
  localparam logic [7:0] W_LBA0 = 8'h03;
  localparam logic [7:0] W_LBA1 = 8'h04;
  localparam logic [7:0] W_LBA2 = 8'h05;
  localparam logic [7:0] W_CMDSET = 8'h07;
  localparam logic [7:0] W_SATA = 8'h08;
  localparam logic [7:0] W_LAST = 8'hff;
  localparam logic [15:0] MASK_MDMA = 16'h0007;
  localparam logic [15:0] MASK_UDMA = 16'h007f;
  localparam logic [15:0] MASK_CMDSET = 16'h3bff;
  localparam logic [15:0] MASK_SATA = 16'h001f;
  // Native capabilities (arbitrary plain values)
  localparam logic [15:0] REVISION = 16'h0001;
  localparam logic [15:0] NATIVE_MDMA = 16'h0007;
  localparam logic [15:0] NATIVE_UDMA = 16'h003f;
  localparam logic [15:0] NATIVE_CMDSET = 16'h3b0f;
  localparam logic [15:0] NATIVE_SATA = 16'h0005;
  localparam logic [47:0] NATIVE_MAX_LBA = 48'h0000_0fff_ffff;
  // Signature value is arbitrary
  localparam logic [7:0] SIGNATURE = 8'ha5;
  // Diagnostic run time
  localparam int CLK_PERIOD_NS = 50;
  localparam int DIAG_TIME_NS = 10000;
  localparam int DIAG_CYCLES =
    (DIAG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// ==== drive_admin_command_handler.sv ====
// Command execution for power query, firmware download, overlay, diags.
// Assumes an Avalon-MM master, synchronous reset, separate power-on reset.
`timescale 1ns/10ps
module drive_admin_command_handler
  import drive_admin_pkg::*;
(
  input wire logic ref_clk, // 20 MHz clock
  input wire logic reset, // Synchronous reset, active high
  input wire logic por, // Power-on reset, active high
  input wire logic [4:0] address, // Avalon byte address
  input wire logic read, // Avalon read
  input wire logic write, // Avalon write
  input wire logic [31:0] writedata, // Avalon write data
  output logic [31:0] readdata, // Avalon read data
  output logic waitrequest, // Avalon wait
  input wire logic [3:0] diag_fault, // Self-test faults: fmt,buf,ecc,cpu
  output logic intrq, // Device interrupt pending
  output logic [15:0] ucode_word, // Firmware word
  output logic ucode_valid, // Firmware word strobe
  output logic [2:0] eff_mdma, // Allowed multiword DMA modes
  output logic [6:0] eff_udma, // Allowed Ultra DMA modes
  output logic [15:0] eff_cmdset, // Allowed command sets
  output logic [15:0] eff_sata, // Allowed serial features
  output logic [47:0] native_max_lba, // Reported native max address
  output logic overlay_frozen // Freeze lock in force
);
  typedef enum logic [2:0] {
    S_IDLE, S_EXEC, S_PIO_IN, S_PIO_OUT, S_DIAG
  } state_e;

  state_e state_q;
  logic ack_q;
  logic [31:0] readdata_q;
  logic [7:0] opc_q, feat_q, cnt_q;
  logic [7:0] seccnt_q, error_q;
  logic err_q, intr_q;
  logic [1:0] pmode_q;
  logic freeze_q;
  logic [7:0] idx_q, sum_q;
  logic [16:0] left_q;
  logic [8:0] diag_cnt_q;
  logic [15:0] ov_mdma_q, ov_udma_q, ov_cmd_q, ov_sata_q;
  logic [47:0] ov_lba_q;
  logic [15:0] e_mdma_q, e_udma_q, e_cmd_q, e_sata_q;
  logic [47:0] e_lba_q;
  logic [15:0] ucode_q;
  logic ucode_v_q;

  function automatic logic hit(input logic [4:0] a, input logic [4:0] r);
    hit = (a == r);
  endfunction

  wire req = read | write;
  wire do_wr = write & ack_q;
  wire do_rd = read & ack_q;
  wire cmd_go = do_wr && hit(address, ADDR_CMD) && state_q == S_IDLE;
  wire data_rd = do_rd && hit(address, ADDR_DATA) && state_q == S_PIO_IN;
  wire data_wr = do_wr && hit(address, ADDR_DATA) && state_q == S_PIO_OUT;
  wire stat_wr = do_wr && hit(address, ADDR_STATUS);
  wire busy = state_q == S_EXEC || state_q == S_DIAG;
  wire drq = state_q == S_PIO_IN || state_q == S_PIO_OUT;
  wire is_overlay = opc_q == OPC_OVERLAY;
  wire is_set = is_overlay && feat_q == FEAT_SET;
  wire [7:0] wr_opc = writedata[7:0];
  wire [7:0] wr_feat = writedata[15:8];
  wire [7:0] wr_cnt = writedata[23:16];
  // R4 subcommand decode
  wire feat_ok = wr_feat >= FEAT_RESTORE && wr_feat <= FEAT_SET;
  // R5 reserved subcommand, R7 frozen overlay
  wire ov_abort = wr_opc == OPC_OVERLAY && (!feat_ok || freeze_q);
  wire known = wr_opc == OPC_POWER_QUERY || wr_opc == OPC_UCODE ||
               wr_opc == OPC_OVERLAY || wr_opc == OPC_DIAG;
  wire go_in = wr_opc == OPC_OVERLAY && wr_feat == FEAT_IDENTIFY;
  wire go_out = wr_opc == OPC_UCODE ||
                (wr_opc == OPC_OVERLAY && wr_feat == FEAT_SET);
  wire [8:0] blocks = (wr_cnt == 8'h00) ? 9'h100 : {1'b0, wr_cnt};
  wire [16:0] ucode_words = {blocks, 8'h00};
  wire [16:0] go_words = (wr_opc == OPC_UCODE) ? ucode_words : 17'h00100;
  wire last_word = left_q == 17'h00001;
  wire diag_done = diag_cnt_q == 9'h000;
  // R22 diagnostic outcome code
  wire [7:0] diag_code = diag_fault[0] ? DIAG_FORMATTER :
                         diag_fault[1] ? DIAG_BUFFER :
                         diag_fault[2] ? DIAG_ECC :
                         diag_fault[3] ? DIAG_CPU : DIAG_PASS;
  // R1 R2 power mode answer
  wire [7:0] pm_answer = (pmode_q == PM_IDLE) ? SC_IDLE : SC_STANDBY;

  // R10 R15 R16 R17 R18 R19 R23 R24 capability word build
  wire [15:0] w_lba = idx_q == W_LBA0 ? e_lba_q[15:0] :
                      idx_q == W_LBA1 ? e_lba_q[31:16] :
                      idx_q == W_LBA2 ? e_lba_q[47:32] : 16'h0000;
  wire [7:0] csum = 8'h00 - sum_q - SIGNATURE;
  wire [15:0] pio_word =
    idx_q == W_REV ? REVISION :
    idx_q == W_MDMA ? (e_mdma_q & MASK_MDMA) :
    idx_q == W_UDMA ? (e_udma_q & MASK_UDMA) :
    idx_q == W_CMDSET ? (e_cmd_q & MASK_CMDSET) :
    idx_q == W_SATA ? (e_sata_q & MASK_SATA) :
    idx_q == W_LAST ? {csum, SIGNATURE} : w_lba;
  wire [7:0] sum_d = sum_q + pio_word[7:0] + pio_word[15:8];

  // R11 R13 overlay applied against native bits
  wire [15:0] ap_mdma = ov_mdma_q & NATIVE_MDMA & MASK_MDMA;
  wire [15:0] ap_udma = ov_udma_q & NATIVE_UDMA & MASK_UDMA;
  wire [15:0] ap_cmd = ov_cmd_q & NATIVE_CMDSET & MASK_CMDSET;
  wire [15:0] ap_sata = ov_sata_q & NATIVE_SATA & MASK_SATA;
  wire [47:0] ap_lba = (ov_lba_q < NATIVE_MAX_LBA) ? ov_lba_q :
                       NATIVE_MAX_LBA;
  wire set_done = state_q == S_PIO_OUT && data_wr && last_word && is_set;
  wire [7:0] out_idx = 8'hff - left_q[7:0] + 8'h01;

  wire [31:0] rd_mux =
    hit(address, ADDR_STATUS) ? {28'h0, intr_q, err_q, drq, busy} :
    hit(address, ADDR_SECCNT) ? {24'h0, seccnt_q} :
    hit(address, ADDR_ERROR) ? {24'h0, error_q} :
    hit(address, ADDR_POWER) ? {30'h0, pmode_q} :
    hit(address, ADDR_DATA) && state_q == S_PIO_IN ? {16'h0, pio_word} :
    32'h0000_0000;

  assign waitrequest = req & ~ack_q;
  assign readdata = readdata_q;
  assign intrq = intr_q;
  assign ucode_word = ucode_q;
  assign ucode_valid = ucode_v_q;
  // R12 cleared capabilities disable the feature
  assign eff_mdma = e_mdma_q[2:0];
  assign eff_udma = e_udma_q[6:0];
  assign eff_cmdset = e_cmd_q;
  assign eff_sata = e_sata_q;
  // R14 native max address follows overlay
  assign native_max_lba = e_lba_q;
  assign overlay_frozen = freeze_q;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ack_q <= 1'b0;
      readdata_q <= 32'h0000_0000;
    end else begin
      ack_q <= req & ~ack_q;
      readdata_q <= rd_mux;
    end
  end

  // R8 freeze cleared only by power loss
  always_ff @(posedge ref_clk) begin
    if (por) begin
      freeze_q <= 1'b0;
    end else if (state_q == S_EXEC && is_overlay && feat_q == FEAT_FREEZE
                 && !err_q) begin
      freeze_q <= 1'b1;
    end
  end

  // R6 restore, R11 set, overlay kept across reset, cleared by por
  always_ff @(posedge ref_clk) begin
    if (por) begin
      e_mdma_q <= NATIVE_MDMA;
      e_udma_q <= NATIVE_UDMA;
      e_cmd_q <= NATIVE_CMDSET;
      e_sata_q <= NATIVE_SATA;
      e_lba_q <= NATIVE_MAX_LBA;
    end else if (state_q == S_EXEC && is_overlay &&
                 feat_q == FEAT_RESTORE && !err_q) begin
      e_mdma_q <= NATIVE_MDMA;
      e_udma_q <= NATIVE_UDMA;
      e_cmd_q <= NATIVE_CMDSET;
      e_sata_q <= NATIVE_SATA;
      e_lba_q <= NATIVE_MAX_LBA;
    end else if (set_done) begin
      e_mdma_q <= ap_mdma;
      e_udma_q <= ap_udma;
      e_cmd_q <= ap_cmd;
      e_sata_q <= ap_sata;
      e_lba_q <= ap_lba;
    end
  end

  // R11 capture overlay block words
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ov_mdma_q <= 16'h0000;
      ov_udma_q <= 16'h0000;
      ov_cmd_q <= 16'h0000;
      ov_sata_q <= 16'h0000;
      ov_lba_q <= 48'h0;
    end else if (data_wr && is_set) begin
      case (out_idx)
        W_MDMA: ov_mdma_q <= writedata[15:0];
        W_UDMA: ov_udma_q <= writedata[15:0];
        W_LBA0: ov_lba_q[15:0] <= writedata[15:0];
        W_LBA1: ov_lba_q[31:16] <= writedata[15:0];
        W_LBA2: ov_lba_q[47:32] <= writedata[15:0];
        W_CMDSET: ov_cmd_q <= writedata[15:0];
        W_SATA: ov_sata_q <= writedata[15:0];
        default: ov_mdma_q <= ov_mdma_q;
      endcase
    end
  end

  // R3 firmware word stream
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ucode_q <= 16'h0000;
      ucode_v_q <= 1'b0;
    end else begin
      ucode_v_q <= data_wr && opc_q == OPC_UCODE;
      if (data_wr && opc_q == OPC_UCODE) begin
        ucode_q <= writedata[15:0];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pmode_q <= PM_IDLE;
    end else if (do_wr && hit(address, ADDR_POWER)) begin
      pmode_q <= writedata[1:0];
    end
  end

  // Interrupt: completion set wins over software clear
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      intr_q <= 1'b0;
    end else if ((state_q == S_EXEC) ||
                 (state_q == S_DIAG && diag_done) ||
                 (drq && last_word && (data_rd || data_wr))) begin
      intr_q <= 1'b1;
    end else if (cmd_go || (stat_wr && writedata[ST_INTRQ])) begin
      intr_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_q <= S_IDLE;
      opc_q <= 8'h00;
      feat_q <= 8'h00;
      cnt_q <= 8'h00;
      seccnt_q <= 8'h00;
      error_q <= 8'h00;
      err_q <= 1'b0;
      idx_q <= 8'h00;
      sum_q <= 8'h00;
      left_q <= 17'h0;
      diag_cnt_q <= 9'h000;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (cmd_go) begin
            opc_q <= wr_opc;
            feat_q <= wr_feat;
            cnt_q <= wr_cnt;
            seccnt_q <= wr_cnt;
            err_q <= ov_abort || !known;
            error_q <= (ov_abort || !known) ? ERR_ABORT : 8'h00;
            idx_q <= 8'h00;
            sum_q <= 8'h00;
            left_q <= go_words;
            diag_cnt_q <= 9'(DIAG_CYCLES - 1);
            if (ov_abort || !known) begin
              state_q <= S_EXEC;
            end else if (wr_opc == OPC_DIAG) begin
              // R21 diagnostics run
              state_q <= S_DIAG;
            end else if (go_in) begin
              // R9 identify data-in
              state_q <= S_PIO_IN;
            end else if (go_out) begin
              state_q <= S_PIO_OUT;
            end else begin
              state_q <= S_EXEC;
            end
          end
        end
        S_EXEC: begin
          // R1 R2 sector count answer
          if (opc_q == OPC_POWER_QUERY && !err_q) begin
            seccnt_q <= pm_answer;
          end
          state_q <= S_IDLE;
        end
        S_PIO_IN: begin
          if (data_rd) begin
            // R20 running byte sum for checksum
            sum_q <= sum_d;
            idx_q <= idx_q + 8'h01;
            left_q <= left_q - 17'h00001;
            if (last_word) begin
              state_q <= S_IDLE;
            end
          end
        end
        S_PIO_OUT: begin
          if (data_wr) begin
            left_q <= left_q - 17'h00001;
            if (last_word) begin
              state_q <= S_IDLE;
            end
          end
        end
        S_DIAG: begin
          diag_cnt_q <= diag_cnt_q - 9'h001;
          if (diag_done) begin
            // R22 outcome into error register
            error_q <= diag_code;
            state_q <= S_IDLE;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  sequence query_go(logic [1:0] pm);
    cmd_go && wr_opc == OPC_POWER_QUERY && pmode_q == pm;
  endsequence

  sequence busy_then_done;
    busy ##1 !busy && intr_q;
  endsequence

  query_idle_a: assert property (@(posedge ref_clk) disable iff (reset) // R2
    query_go(PM_IDLE) |=> busy_then_done ##0 seccnt_q == SC_IDLE)
    else $error("idle query did not answer ffh");

  query_stby_a: assert property (@(posedge ref_clk) disable iff (reset) // R1
    query_go(PM_STANDBY) |=> busy_then_done ##0 seccnt_q == SC_STANDBY)
    else $error("standby query did not answer 00h");

  reserved_abort_a: assert property (@(posedge ref_clk) // R5
    disable iff (reset)
    cmd_go && wr_opc == OPC_OVERLAY && !feat_ok |=>
      ##1 err_q && error_q == ERR_ABORT && !busy)
    else $error("reserved overlay feature not aborted");

  frozen_abort_a: assert property (@(posedge ref_clk) // R7
    disable iff (reset)
    cmd_go && wr_opc == OPC_OVERLAY && freeze_q |=> ##1 err_q && !drq)
    else $error("overlay accepted while frozen");

  freeze_hold_a: assert property (@(posedge ref_clk) // R8
    freeze_q && !por |=> freeze_q)
    else $error("freeze lost without power loss");

  overlay_native_a: assert property (@(posedge ref_clk) // R13
    disable iff (por)
    (e_cmd_q & ~NATIVE_CMDSET) == 16'h0000 && e_lba_q <= NATIVE_MAX_LBA)
    else $error("overlay enabled a non native capability");

  ident_reserved_a: assert property (@(posedge ref_clk) // R24
    disable iff (reset)
    state_q == S_PIO_IN && idx_q > W_SATA && idx_q < W_LAST |->
      pio_word == 16'h0000)
    else $error("reserved identify word not zero");

  checksum_a: assert property (@(posedge ref_clk) // R20
    disable iff (reset)
    state_q == S_PIO_IN && idx_q == W_LAST |-> sum_d == 8'h00)
    else $error("identify checksum does not zero the sum");

  diag_time_a: assert property (@(posedge ref_clk) // R21
    disable iff (reset)
    cmd_go && wr_opc == OPC_DIAG |=> busy [*8] ##1 busy)
    else $error("diagnostics finished too early");

  wait_first_a: assert property (@(posedge ref_clk) disable iff (reset)
    req && !ack_q |-> waitrequest ##1 !waitrequest)
    else $error("bus answer not after one wait cycle");
endmodule

// ==== host_master_model.sv ====
// Host side bus master model for the admin command handler.
// Assumes an Avalon-MM slave with waitrequest on one shared clock.
`timescale 1ns/10ps
module host_master_model (
  input wire logic ref_clk, // Bus clock
  output logic [4:0] address, // Avalon address
  output logic read, // Avalon read
  output logic write, // Avalon write
  output logic [31:0] writedata, // Avalon write data
  input wire logic [31:0] readdata, // Avalon read data
  input wire logic waitrequest, // Avalon wait
  output logic hang // Slave never answered
);
  initial begin
    address = 5'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    hang = 1'b0;
  end

  // One transfer, held until waitrequest is sampled low
  task automatic xfer(input logic wr, input logic [4:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge ref_clk);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= ~wr;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 64);
    q = readdata;
    if (waitrequest !== 1'b0) hang <= 1'b1;
    read <= 1'b0;
    write <= 1'b0;
    // Released data no longer shows the last value
    writedata <= ~d;
  endtask
endmodule

// ==== drive_admin_command_handler_tb.sv ====
// Self-checking bench for the drive admin command handler.
// Assumes the host model drives the bus; bench drives reset and faults.
`timescale 1ns/10ps
module drive_admin_command_handler_tb
  import drive_admin_pkg::*;
;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic por = 1'b1;
  logic [3:0] diag_fault = 4'h0;
  logic [4:0] address;
  logic read, write, waitrequest, intrq, ucode_valid, overlay_frozen, hang;
  logic [31:0] writedata, readdata;
  logic [15:0] ucode_word, eff_cmdset, eff_sata, ucode_last;
  logic [2:0] eff_mdma;
  logic [6:0] eff_udma;
  logic [47:0] native_max_lba;
  logic [15:0] exp_w [0:8];
  int bad_count = 0;
  int checked = 0;
  int ucode_n = 0;

  always #25 ref_clk = ~ref_clk;

  host_master_model host_master_model_inst (.ref_clk(ref_clk),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .hang(hang));

  drive_admin_command_handler drive_admin_command_handler_inst (
    .ref_clk(ref_clk), .reset(reset), .por(por), .address(address),
    .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest),
    .diag_fault(diag_fault), .intrq(intrq), .ucode_word(ucode_word),
    .ucode_valid(ucode_valid), .eff_mdma(eff_mdma), .eff_udma(eff_udma),
    .eff_cmdset(eff_cmdset), .eff_sata(eff_sata),
    .native_max_lba(native_max_lba), .overlay_frozen(overlay_frozen));

  always @(posedge ref_clk) begin
    if (ucode_valid === 1'b1) begin
      ucode_n++;
      ucode_last = ucode_word;
    end
    if (hang === 1'b1) begin
      bad_count++;
      summarize();
    end
  end

  initial begin
    repeat (90000) @(posedge ref_clk);
    bad_count++;
    summarize();
  end

  task automatic summarize();
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    host_master_model_inst.xfer(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [4:0] a, output logic [31:0] q);
    host_master_model_inst.xfer(1'b0, a, 32'h0, q);
  endtask

  // Polls status until busy drops, bounded
  task automatic done(output logic [31:0] s);
    int n;
    n = 0;
    do begin
      rd(ADDR_STATUS, s);
      n++;
    end while (s[ST_BUSY] !== 1'b0 && n < 400);
    if (s[ST_BUSY] !== 1'b0) begin
      bad_count++;
      summarize();
    end
  endtask

  task automatic cmd(input logic [7:0] opc, input logic [7:0] feat,
                     input logic [7:0] sc, output logic [31:0] s);
    wr(ADDR_CMD, {8'h00, sc, feat, opc});
    done(s);
  endtask

  task automatic identify_chk();
    logic [31:0] q;
    logic [7:0] sum;
    cmd(OPC_OVERLAY, FEAT_IDENTIFY, 8'h00, q);
    chk(48'(q[ST_DRQ]), 48'h1);
    sum = 8'h00;
    for (int i = 0; i < 256; i++) begin
      rd(ADDR_DATA, q);
      sum = sum + q[7:0] + q[15:8];
      if (i < 9)
        chk(48'(q[15:0]), 48'(exp_w[i]));
      else if (i < 255) chk(48'(q[15:0]), 48'h0);
      else chk(48'(q[7:0]), 48'(SIGNATURE));
    end
    chk(48'(sum), 48'h0);
    rd(ADDR_STATUS, q);
    chk(48'(q[ST_INTRQ:ST_BUSY]), 48'h8);
    wr(ADDR_STATUS, 32'h8);
  endtask

  task automatic abort_chk(input logic [31:0] s);
    logic [31:0] q;
    chk(48'(s[ST_ERR]), 48'h1);
    rd(ADDR_ERROR, q);
    chk(48'(q[7:0]), 48'(ERR_ABORT));
    wr(ADDR_STATUS, 32'h8);
  endtask

  task automatic pulse(input logic p);
    @(posedge ref_clk);
    reset <= 1'b1;
    por <= p;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    por <= 1'b0;
    @(posedge ref_clk);
  endtask

  initial begin
    logic [31:0] s;
    logic [31:0] q;
    logic [7:0] resv [0:3];
    logic [15:0] ov [0:8];
    resv = '{8'h00, 8'hbf, 8'hc4, 8'hff};
    ov = '{16'h0, 16'h0003, 16'h00ff, 16'h0000, 16'h0010, 16'h0, 16'h0,
           16'hfff7, 16'h0004};
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    por <= 1'b0;
    rd(5'h18, q);
    chk(48'(q), 48'h0);
    for (int pm = 0; pm < 4; pm++) begin
      wr(ADDR_POWER, 32'(pm));
      cmd(OPC_POWER_QUERY, 8'h00, 8'h00, s);
      chk(48'(s[ST_INTRQ]), 48'h1);
      chk(48'(intrq), 48'h1);
      rd(ADDR_SECCNT, q);
      chk(48'(q[7:0]), 48'(pm == 0 ? SC_IDLE : SC_STANDBY));
      wr(ADDR_STATUS, 32'h8);
      rd(ADDR_STATUS, q);
      chk(48'(q[ST_INTRQ]), 48'h0);
    end
    for (int i = 0; i < 5; i++) begin
      diag_fault <= (i == 0) ? 4'h0 : 4'(4'hf << (i - 1));
      wr(ADDR_CMD, {24'h0, OPC_DIAG});
      rd(ADDR_STATUS, q);
      chk(48'(q[ST_BUSY]), 48'h1);
      done(s);
      rd(ADDR_ERROR, q);
      chk(48'(q[7:0]), 48'(DIAG_PASS + 8'(i)));
      wr(ADDR_STATUS, 32'h8);
    end
    for (int i = 0; i < 4; i++) begin
      cmd(OPC_OVERLAY, resv[i], 8'h00, s);
      abort_chk(s);
    end
    exp_w = '{REVISION, NATIVE_MDMA, NATIVE_UDMA, NATIVE_MAX_LBA[15:0],
              NATIVE_MAX_LBA[31:16], NATIVE_MAX_LBA[47:32], 16'h0,
              NATIVE_CMDSET, NATIVE_SATA};
    identify_chk();
    // Host sends the overlay block
    wr(ADDR_CMD, {16'h0, FEAT_SET, OPC_OVERLAY});
    for (int i = 0; i < 256; i++)
      wr(ADDR_DATA, {16'h0, (i < 9) ? ov[i] : 16'h0});
    done(s);
    chk(48'(eff_mdma), 48'h3);
    chk(48'(eff_udma), 48'h3f);
    chk(48'(eff_cmdset), 48'h3b07);
    chk(48'(eff_sata), 48'h4);
    chk(native_max_lba, 48'h0000_0010_0000);
    exp_w = '{REVISION, 16'h0003, 16'h003f, 16'h0000, 16'h0010, 16'h0,
              16'h0, 16'h3b07, 16'h0004};
    identify_chk();
    pulse(1'b0);
    chk(48'(eff_cmdset), 48'h3b07);
    cmd(OPC_OVERLAY, FEAT_RESTORE, 8'h00, s);
    chk(48'(eff_mdma), 48'(NATIVE_MDMA));
    chk(48'(eff_cmdset), 48'(NATIVE_CMDSET));
    chk(native_max_lba, NATIVE_MAX_LBA);
    cmd(OPC_OVERLAY, FEAT_FREEZE, 8'h00, s);
    chk(48'(overlay_frozen), 48'h1);
    for (int f = 0; f < 4; f++) begin
      cmd(OPC_OVERLAY, FEAT_RESTORE + 8'(f), 8'h00, s);
      abort_chk(s);
    end
    pulse(1'b0);
    chk(48'(overlay_frozen), 48'h1);
    pulse(1'b1);
    chk(48'(overlay_frozen), 48'h0);
    cmd(OPC_OVERLAY, FEAT_RESTORE, 8'h00, s);
    chk(48'(s[ST_ERR]), 48'h0);
    // Host streams one block of firmware
    wr(ADDR_CMD, {8'h00, 8'h01, 8'h00, OPC_UCODE});
    for (int i = 0; i < 256; i++)
      wr(ADDR_DATA, 32'h1000 + 32'(i));
    done(s);
    chk(48'(ucode_n), 48'h100);
    chk(48'(ucode_last), 48'h10ff);
    summarize();
  end
endmodule
